// >>> logic/rbs_pkg.sv
// rbs_pkg: constants shared by both ends of the receive bit synchronizer link
// assumes: 3-wire frame of 14 bits (r/w, 5 address bits, 8 data bits), msb first
package rbs_pkg;
    // ----------------------------------------
    // device register addresses on the 3-wire bus
    // ----------------------------------------
    localparam logic [4:0] RA_RXTX   = 5'h00; // rxtx_parameters: [0] sync enable, [1] spreading
    localparam logic [4:0] RA_DIV    = 5'h01; // synth_parameters: [6:0] rx_rate_divisor
    localparam logic [4:0] RA_EXTRA  = 5'h02; // extra_parameters: [0] fixed_rate_mode_enable
    localparam logic [4:0] RA_SEL    = 5'h03; // param_set_selector
    localparam logic [4:0] RA_SW0    = 5'h04; // switchable_param_sets, set 0: [1:0] mode sel b,a
    localparam logic [4:0] RA_SW1    = 5'h05; // switchable_param_sets, set 1
    localparam logic [4:0] RA_STAT   = 5'h06; // [0] spreading, [1] transmit, [2] locked
    localparam logic [1:0] RXTX_RST  = 2'h1;
    localparam logic [6:0] DIV_RST   = 7'h1f;
    localparam int         SYNC_BIT  = 0;
    localparam int         SPRD_BIT  = 1;
    // ----------------------------------------
    // frame, rate and spreading constants
    // ----------------------------------------
    localparam logic [3:0]  FRAME_BITS = 4'hd;  // index of last frame bit
    localparam logic [3:0]  ADDR_END   = 4'h5;  // index of last address bit
    localparam int          BASE_RATE_HZ = 152340;
    localparam int          FIX_RATE_HZ  = 32700;
    localparam int          BLEN       = 11;
    localparam logic [10:0] BARKER     = 11'h712;
    localparam logic [3:0]  CORR_MIN   = 4'h9;  // chip matches for a bit decision
    localparam logic [4:0]  LOCK_BITS  = 5'h18; // 24 alternating bits = 3 preamble bytes
    // ----------------------------------------
    // host apb map
    // ----------------------------------------
    localparam logic [7:0] HA_CMD  = 8'h00;
    localparam logic [7:0] HA_STAT = 8'h04;
    localparam logic [7:0] HA_RXD  = 8'h08;
    localparam logic [7:0] HA_CTRL = 8'h0c;
    localparam int         CMD_RD  = 13;
endpackage

// >>> logic/rbs_if.sv
// rbs_if: pins between the transceiver back end and its host controller
// assumes: the bench drives the link clock; the data pin is resolved here
`timescale 1ns/1ps
interface rbs_if;
    logic sck;
    logic si;
    logic en;
    logic so;
    logic sw;
    logic recovered_bit_clock;
    logic d_dev_o;
    logic d_dev_oe;
    logic d_host_o;
    logic d_host_oe;
    logic data_line;
    assign data_line = d_dev_oe ? d_dev_o : (d_host_oe ? d_host_o : 1'b0);
    modport dev (input sck, si, en, sw, data_line, output so, recovered_bit_clock, d_dev_o, d_dev_oe);
    modport host (input so, recovered_bit_clock, data_line, output sck, si, en, sw, d_host_o, d_host_oe);
endinterface

// >>> logic/rbs_dev.sv
// rbs_dev: receive bit synchronizer, spreading codec and 3-wire register port
// assumes: runs on the reference (link) clock; host pins arrive asynchronously
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module rbs_dev #(
    parameter int LCLK_HZ    = 83333333,
    parameter int PRESC      = LCLK_HZ / rbs_pkg::BASE_RATE_HZ,
    parameter int FIX_PERIOD = LCLK_HZ / rbs_pkg::FIX_RATE_HZ
) (
    input  wire logic       LCLK,
    input  wire logic       RSTN,
    rbs_if.dev              LNK,
    input  wire logic       DEMOD_IN,
    output logic            MOD_OUT,
    output logic [1:0]      FE_MODE,
    output logic            LOCKED
);
    // ----------------------------------------
    // pin synchronisers {data, switch, si, sck, en}
    // ----------------------------------------
    logic [4:0]  s1, s2, s3, st;
    logic        sck_d;
    always_ff @(posedge LCLK or negedge RSTN)
        if (!RSTN)
        begin
            s1 <= 5'h00;
            s2 <= 5'h00;
            s3 <= 5'h00;
            st <= 5'h00;
            sck_d <= 1'b0;
        end
        else
        begin
            s1 <= {LNK.data_line, LNK.sw, LNK.si, LNK.sck, LNK.en};
            s2 <= s1;
            s3 <= s2;
            st <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & st);
            sck_d <= st[1];
        end
    wire sck_rise = st[1] & ~sck_d;
    wire sck_fall = ~st[1] & sck_d;
    wire tx       = st[3];
    // ----------------------------------------
    // 3-wire frame and registers
    // ----------------------------------------
    logic [12:0] sh;
    logic [3:0]  bcnt;
    logic [7:0]  rd_sh, rd_val;
    logic        rd_act, so_reg;
    logic [1:0]  rxtx_reg, sw0_reg, sw1_reg;
    logic [6:0]  div_reg;
    logic        extra_reg, sel_reg;
    wire  [13:0] wd = {sh, st[2]};
    always_ff @(posedge LCLK or negedge RSTN)
        if (!RSTN)
        begin
            sh <= 13'h0000;
            bcnt <= 4'h0;
            rd_sh <= 8'h00;
            rd_act <= 1'b0;
            so_reg <= 1'b0;
        end
        else if (!st[0])
        begin
            bcnt <= 4'h0;
            rd_act <= 1'b0;
            so_reg <= 1'b0;
        end
        else if (sck_rise && bcnt <= rbs_pkg::FRAME_BITS)
        begin
            sh <= wd[12:0];
            bcnt <= bcnt + 4'h1;
            if (bcnt == rbs_pkg::ADDR_END)
            begin
                rd_act <= wd[5];
                rd_sh <= rd_val;
            end
        end
        else if (sck_fall && rd_act && bcnt > rbs_pkg::ADDR_END)
        begin
            so_reg <= rd_sh[7];
            rd_sh <= {rd_sh[6:0], 1'b0};
        end
    always_ff @(posedge LCLK or negedge RSTN)
        if (!RSTN)
        begin
            rxtx_reg <= rbs_pkg::RXTX_RST;
            div_reg <= rbs_pkg::DIV_RST;
            extra_reg <= 1'b0;
            sel_reg <= 1'b0;
            sw0_reg <= 2'h0;
            sw1_reg <= 2'h0;
        end
        else if (st[0] && sck_rise && bcnt == rbs_pkg::FRAME_BITS && !wd[13])
        begin
            case (wd[12:8])
                rbs_pkg::RA_RXTX:  rxtx_reg <= wd[1:0];
                rbs_pkg::RA_DIV:   div_reg <= wd[6:0];
                rbs_pkg::RA_EXTRA: extra_reg <= wd[0];
                rbs_pkg::RA_SEL:   sel_reg <= wd[0];
                rbs_pkg::RA_SW0:   sw0_reg <= wd[1:0];
                rbs_pkg::RA_SW1:   sw1_reg <= wd[1:0];
                default:           ;
            endcase
        end
    always_comb
    begin
        case ({sh[3:0], st[2]})
            rbs_pkg::RA_RXTX:  rd_val = {6'h00, rxtx_reg};
            rbs_pkg::RA_DIV:   rd_val = {1'b0, div_reg};
            rbs_pkg::RA_EXTRA: rd_val = {7'h00, extra_reg};
            rbs_pkg::RA_SEL:   rd_val = {7'h00, sel_reg};
            rbs_pkg::RA_SW0:   rd_val = {6'h00, sw0_reg};
            rbs_pkg::RA_SW1:   rd_val = {6'h00, sw1_reg};
            rbs_pkg::RA_STAT:  rd_val = {5'h00, LOCKED, tx, rxtx_reg[rbs_pkg::SPRD_BIT]};
            default:           rd_val = 8'h00;
        endcase
    end
    // ----------------------------------------
    // rate and phase counter
    // ----------------------------------------
    wire spread = rxtx_reg[rbs_pkg::SPRD_BIT];
    wire bypass = ~rxtx_reg[rbs_pkg::SYNC_BIT] & ~spread;
    logic [17:0] period, per, cnt;
    always_comb
    begin
        period = extra_reg ? 18'(FIX_PERIOD) : 18'((32'(div_reg) + 1) * PRESC);
        per = spread ? 18'(period / 18'(rbs_pkg::BLEN)) : period;
    end
    wire [17:0] half = per >> 1;
    logic [2:0] dh;
    logic       filt, filt_d;
    always_ff @(posedge LCLK or negedge RSTN)
        if (!RSTN)
        begin
            dh <= 3'h0;
            filt <= 1'b0;
            filt_d <= 1'b0;
        end
        else
        begin
            dh <= {dh[1:0], DEMOD_IN};
            filt <= (dh[0] & dh[1]) | (dh[1] & dh[2]) | (dh[0] & dh[2]);
            filt_d <= filt;
        end
    wire trans = (filt ^ filt_d) & ~tx;
    wire tick  = cnt >= per - 18'h1;
    wire mid   = cnt == half;
    always_ff @(posedge LCLK or negedge RSTN)
        if (!RSTN)
            cnt <= 18'h0;
        else if (bypass && !tx)
            cnt <= 18'h0;
        else if (trans)
            cnt <= (cnt < half) ? (cnt >> 1) : cnt + ((per - cnt) >> 1);
        else
            cnt <= tick ? 18'h0 : cnt + 18'h1;
    // ----------------------------------------
    // bit sampling, lock and chip correlation
    // ----------------------------------------
    function automatic logic [3:0] rbs_ones(input logic [10:0] v);
        rbs_ones = 4'h0;
        for (int i = 0; i < rbs_pkg::BLEN; i++)
            rbs_ones = rbs_ones + {3'h0, v[i]};
    endfunction
    logic        samp, mid_d;
    logic [4:0]  lock_cnt;
    logic [10:0] chips;
    always_ff @(posedge LCLK or negedge RSTN)
        if (!RSTN)
        begin
            samp <= 1'b0;
            mid_d <= 1'b0;
            lock_cnt <= 5'h00;
            chips <= 11'h000;
            LOCKED <= 1'b0;
        end
        else
        begin
            mid_d <= mid & ~tx & spread;
            LOCKED <= lock_cnt >= rbs_pkg::LOCK_BITS;
            if (bypass || tx)
                lock_cnt <= 5'h00;
            else if (mid)
            begin
                samp <= filt;
                chips <= {chips[9:0], filt};
                if (filt != samp && lock_cnt < rbs_pkg::LOCK_BITS)
                    lock_cnt <= lock_cnt + 5'h01;
                else if (filt == samp && lock_cnt < rbs_pkg::LOCK_BITS)
                    lock_cnt <= 5'h00;
            end
        end
    wire [3:0] match = rbs_ones(~(chips ^ rbs_pkg::BARKER));
    wire det1 = match >= rbs_pkg::CORR_MIN;
    wire det0 = match <= 4'(rbs_pkg::BLEN) - rbs_pkg::CORR_MIN;
    // ----------------------------------------
    // pin drivers: data, recovered clock, modulator
    // ----------------------------------------
    logic [3:0] idx;
    logic       txb, d_o, d_oe, recovered_bit_clock_reg;
    wire  [3:0] cidx = (idx > 4'ha) ? 4'h0 : idx;
    always_ff @(posedge LCLK or negedge RSTN)
        if (!RSTN)
        begin
            idx <= 4'h0;
            txb <= 1'b0;
            d_o <= 1'b0;
            d_oe <= 1'b0;
            recovered_bit_clock_reg <= 1'b0;
            MOD_OUT <= 1'b0;
        end
        else if (tx)
        begin
            d_oe <= 1'b0;
            recovered_bit_clock_reg <= cnt >= half;
            if (tick && spread)
            begin
                idx <= (cidx >= 4'(rbs_pkg::BLEN - 1)) ? 4'h0 : cidx + 4'h1;
                if (cidx == 4'h0)
                    txb <= st[4];
                MOD_OUT <= ~(((cidx == 4'h0) ? st[4] : txb) ^ rbs_pkg::BARKER[4'ha - cidx]);
            end
            else if (tick)
                MOD_OUT <= st[4];
        end
        else
        begin
            MOD_OUT <= 1'b0;
            d_oe <= 1'b1;
            if (bypass)
            begin
                d_o <= DEMOD_IN;
                recovered_bit_clock_reg <= 1'b0;
            end
            else if (spread)
            begin
                if (mid_d && (det1 || det0))
                begin
                    d_o <= det1;
                    idx <= 4'h0;
                end
                else if (tick && idx < 4'hf)
                    idx <= idx + 4'h1;
                recovered_bit_clock_reg <= idx >= 4'h5 && idx <= 4'ha;
            end
            else
            begin
                if (tick)
                    d_o <= samp;
                recovered_bit_clock_reg <= cnt >= half;
            end
        end
    always_ff @(posedge LCLK or negedge RSTN)
        if (!RSTN)
            FE_MODE <= 2'h0;
        else
            FE_MODE <= sel_reg ? sw1_reg : sw0_reg;
    assign LNK.so       = so_reg;
    assign LNK.recovered_bit_clock     = recovered_bit_clock_reg;
    assign LNK.d_dev_o  = d_o;
    assign LNK.d_dev_oe = d_oe;
endmodule // rbs_dev

// >>> logic/rbs_host.sv
// rbs_host: host controller end; apb registers, 3-wire master, data sampler
// assumes: apb master on CLK; device pins arrive from the link clock domain
`timescale 1ns/1ps
module rbs_host #(
    parameter int SCK_HALF = 125
) (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    rbs_if.host              LNK
);
    typedef enum logic [1:0] {S_IDLE = 2'b00, S_LO = 2'b01, S_HI = 2'b10, S_END = 2'b11} rbs_st_e;
    // ----------------------------------------
    // synchronisers {so, data, recovered_bit_clock}
    // ----------------------------------------
    logic [2:0] s1, s2, s3, st;
    logic       recovered_bit_clock_d;
    always_ff @(posedge CLK or negedge RSTN)
        if (!RSTN)
        begin
            s1 <= 3'h0;
            s2 <= 3'h0;
            s3 <= 3'h0;
            st <= 3'h0;
            recovered_bit_clock_d <= 1'b0;
        end
        else
        begin
            s1 <= {LNK.so, LNK.data_line, LNK.recovered_bit_clock};
            s2 <= s1;
            s3 <= s2;
            st <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & st);
            recovered_bit_clock_d <= st[0];
        end
    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic [13:0] cmd_reg;
    logic [7:0]  rd_reg, rx_byte;
    logic [1:0]  ctrl_reg;
    logic        busy, rx_valid, pre_ok, rearm;
    rbs_st_e     state;
    wire setup = PSEL & ~PENABLE;
    wire wr    = PSEL & PENABLE & PREADY & PWRITE;
    always_ff @(posedge CLK or negedge RSTN)
        if (!RSTN)
        begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            ctrl_reg <= 2'h0;
            rearm <= 1'b0;
        end
        else
        begin
            PREADY <= setup;
            rearm <= wr && PADDR == rbs_pkg::HA_CTRL && PWDATA[2];
            PSLVERR <= setup && !(PADDR == rbs_pkg::HA_CMD || PADDR == rbs_pkg::HA_STAT
                || PADDR == rbs_pkg::HA_RXD || PADDR == rbs_pkg::HA_CTRL);
            if (wr && PADDR == rbs_pkg::HA_CTRL)
                ctrl_reg <= PWDATA[1:0];
            case (PADDR)
                rbs_pkg::HA_CMD:  PRDATA <= {18'h00000, cmd_reg};
                rbs_pkg::HA_STAT: PRDATA <= {16'h0000, rd_reg, 7'h00, busy};
                rbs_pkg::HA_RXD:  PRDATA <= {22'h000000, pre_ok, rx_valid, rx_byte};
                rbs_pkg::HA_CTRL: PRDATA <= {30'h00000000, ctrl_reg};
                default:          PRDATA <= 32'h00000000;
            endcase
        end
    // ----------------------------------------
    // 3-wire master
    // ----------------------------------------
    logic [7:0]  div;
    logic [3:0]  bit_i;
    logic [13:0] tx_sh;
    logic        sck_reg, si_reg, en_reg;
    always_ff @(posedge CLK or negedge RSTN)
        if (!RSTN)
        begin
            state <= S_IDLE;
            div <= 8'h00;
            bit_i <= 4'h0;
            tx_sh <= 14'h0000;
            cmd_reg <= 14'h0000;
            rd_reg <= 8'h00;
            sck_reg <= 1'b0;
            si_reg <= 1'b0;
            en_reg <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            div <= (state == S_IDLE || div == 8'(SCK_HALF - 1)) ? 8'h00 : div + 8'h01;
            case (state)
                S_IDLE:
                    if (wr && PADDR == rbs_pkg::HA_CMD)
                    begin
                        cmd_reg <= PWDATA[13:0];
                        tx_sh <= PWDATA[13:0];
                        en_reg <= 1'b1;
                        busy <= 1'b1;
                        bit_i <= 4'h0;
                        state <= S_LO;
                    end
                S_LO:
                    begin
                        si_reg <= tx_sh[13];
                        if (div == 8'(SCK_HALF - 1))
                        begin
                            sck_reg <= 1'b1;
                            state <= S_HI;
                        end
                    end
                S_HI:
                    if (div == 8'(SCK_HALF - 1))
                    begin
                        sck_reg <= 1'b0;
                        tx_sh <= {tx_sh[12:0], 1'b0};
                        if (bit_i > rbs_pkg::ADDR_END)
                            rd_reg <= {rd_reg[6:0], st[2]};
                        bit_i <= bit_i + 4'h1;
                        state <= (bit_i == rbs_pkg::FRAME_BITS) ? S_END : S_LO;
                    end
                S_END:
                    if (div == 8'(SCK_HALF - 1))
                    begin
                        en_reg <= 1'b0;
                        // en held low half a bit before busy clears
                        if (!en_reg)
                        begin
                            busy <= 1'b0;
                            state <= S_IDLE;
                        end
                    end
                default:
                    state <= S_IDLE;
            endcase
        end
    // ----------------------------------------
    // receive sampler on recovered clock
    // ----------------------------------------
    logic [4:0] alt;
    logic [2:0] nb;
    logic       last;
    wire recovered_bit_clock_rise = st[0] & ~recovered_bit_clock_d;
    wire rd_rxd    = setup & ~PWRITE & (PADDR == rbs_pkg::HA_RXD);
    always_ff @(posedge CLK or negedge RSTN)
        if (!RSTN)
        begin
            alt <= 5'h00;
            nb <= 3'h0;
            last <= 1'b0;
            pre_ok <= 1'b0;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
        end
        else
        begin
            if (rd_rxd || rearm)
                rx_valid <= 1'b0;
            if (rearm)
            begin
                pre_ok <= 1'b0;
                alt <= 5'h00;
            end
            if (recovered_bit_clock_rise && !ctrl_reg[0])
            begin
                last <= st[1];
                if (!pre_ok)
                begin
                    alt <= (st[1] != last) ? alt + 5'h01 : 5'h00;
                    pre_ok <= alt + 5'h01 >= rbs_pkg::LOCK_BITS && st[1] != last;
                    nb <= 3'h0;
                end
                else
                begin
                    rx_byte <= {rx_byte[6:0], st[1]};
                    nb <= nb + 3'h1;
                    if (nb == 3'h7)
                        rx_valid <= 1'b1;
                end
            end
        end
    assign LNK.sck       = sck_reg;
    assign LNK.si        = si_reg;
    assign LNK.en        = en_reg;
    assign LNK.sw        = ctrl_reg[0];
    assign LNK.d_host_o  = ctrl_reg[1];
    assign LNK.d_host_oe = ctrl_reg[0];
endmodule // rbs_host

// >>> verif/rbs_checker.sv
// rbs_checker: timing of the pins between device and host
// assumes: placed beside rbs_if; host built with SCK_HALF of 8 to 20
`timescale 1ns/1ps
module rbs_checker (
    input wire logic CLK,
    input wire logic LCLK,
    input wire logic RSTN,
    input wire logic sck,
    input wire logic si,
    input wire logic en,
    input wire logic sw,
    input wire logic recovered_bit_clock,
    input wire logic d_dev_o,
    input wire logic d_dev_oe
);
    // ----------------------------
    // link cycles since reset
    // ----------------------------
    logic [2:0] age_reg;
    always_ff @(posedge LCLK or negedge RSTN)
        if (!RSTN)
            age_reg <= 3'h0;
        else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;
    // ----------------------------
    // data pin and recovered clock
    // ----------------------------
    a_rx_pin_out: assert property (
        @(posedge LCLK) disable iff (!RSTN) (age_reg == 3'h7 && !sw)[*6] |-> d_dev_oe)
        else $error("data pin not driven in receive");
    a_tx_pin_free: assert property (
        @(posedge LCLK) disable iff (!RSTN) sw[*6] |-> !d_dev_oe)
        else $error("data pin driven in transmit");
    a_bit_mid_stable: assert property (
        @(posedge LCLK) disable iff (!RSTN) $rose(recovered_bit_clock) |-> $stable(d_dev_o))
        else $error("data moved at recovered clock rise");
    // ----------------------------
    // three-wire frames
    // ----------------------------
    a_sck_idle_low: assert property (
        @(posedge CLK) disable iff (!RSTN) !en |-> !sck)
        else $error("serial clock active outside frame");
    a_sck_high_len: assert property (
        @(posedge CLK) disable iff (!RSTN) $rose(sck) |-> sck[*8])
        else $error("serial clock high phase short");
    a_sck_low_len: assert property (
        @(posedge CLK) disable iff (!RSTN) $fell(sck) |-> !sck[*8])
        else $error("serial clock low phase short");
    a_si_steady: assert property (
        @(posedge CLK) disable iff (!RSTN) sck |-> $stable(si))
        else $error("serial data moved while clock high");
    a_frame_bound: assert property (
        @(posedge CLK) disable iff (!RSTN) $rose(en) |-> (en && !sck)[*8] ##[1:600] !en)
        else $error("frame start or length wrong");
endmodule // rbs_checker

// >>> verif/rx_bit_synchronizer_tb.sv
// rx_bit_synchronizer_tb: device and host joined, driven over apb and demod input
// assumes: package, interface, both ends and checker compiled first
`timescale 1ns/1ps
module rx_bit_synchronizer_tb;
    localparam int PRE  = 4;
    localparam int FIXP = 20;
    logic        clk = 1'h0, lclk = 1'h0, rstn = 1'h0, demod = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, mod_out, locked;
    logic [1:0]  fe_mode;
    logic [63:0] rx_sh = 64'h0;
    logic [10:0] bk = 11'h0;
    time         t_rise = 0, per = 0;
    int          errors = 0, samples_checked = 0;
    int          dv[3] = '{0, 5, 127};
    rbs_if lnk ();
    always #2 clk = ~clk;
    initial
    begin
        #1.3;
        forever #6 lclk = ~lclk;
    end
    rbs_dev #(.PRESC(PRE), .FIX_PERIOD(FIXP)) rbs_dev_inst (.LCLK(lclk), .RSTN(rstn),
        .LNK(lnk), .DEMOD_IN(demod), .MOD_OUT(mod_out), .FE_MODE(fe_mode), .LOCKED(locked));
    rbs_host #(.SCK_HALF(16)) rbs_host_inst (.CLK(clk), .RSTN(rstn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LNK(lnk));
    rbs_checker rbs_checker_inst (.CLK(clk), .LCLK(lclk), .RSTN(rstn), .sck(lnk.sck),
        .si(lnk.si), .en(lnk.en), .sw(lnk.sw), .recovered_bit_clock(lnk.recovered_bit_clock), .d_dev_o(lnk.d_dev_o),
        .d_dev_oe(lnk.d_dev_oe));
    // ----------------------------
    // host side sampler
    // ----------------------------
    always @(posedge lnk.recovered_bit_clock)
    begin
        rx_sh <= {rx_sh[62:0], lnk.data_line};
        per <= $time - t_rise;
        t_rise <= $time;
    end
    // ----------------------------
    // shared tasks
    // ----------------------------
    task automatic lw(input int n);
        repeat (n) @(posedge lclk);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic dev(input logic [4:0] a, input logic [7:0] d, input logic rd,
                       output logic [7:0] q);
        logic [31:0] r;
        logic        e;
        apb(1'h1, rbs_pkg::HA_CMD, {18'h0, rd, a, d}, r, e);
        do apb(1'h0, rbs_pkg::HA_STAT, 32'h0, r, e); while (r[0] !== 1'h0);
        q = r[15:8];
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        dev(a, d, 1'h0, q);
    endtask
    task automatic bit_out(input logic b, input logic sp, input int p);
        for (int i = 0; i < (sp ? 11 : p); i++)
        begin
            @(posedge lclk);
            demod <= sp ? ~(b ^ bk[10 - i]) : b ^ (i == 2);
            if (sp)
                lw(p / 11 - 1);
        end
    endtask
    task automatic rx_run(input logic [15:0] pat, input int lead, input int run,
                          input logic sp, input int p);
        int k;
        for (int i = 0; i < lead; i++) bit_out(i[0], sp, p);
        for (int i = 15; i >= 0; i--) bit_out(pat[i], sp, p);
        for (int i = 0; i < run + 3; i++) bit_out(1'h1, sp, p);
        k = 0;
        while (rx_sh[k] === 1'h1 && k < 60) k++;
        check(32'(k >= run && k <= run + 3), 32'h1);
        check({16'h0, 16'(rx_sh >> k)}, {16'h0, pat});
    endtask
    function automatic logic rot(input logic [10:0] c, input logic [10:0] r);
        rot = 1'h0;
        for (int i = 0; i < 11; i++) if (11'({c, c} >> i) === r) rot = 1'h1;
    endfunction
    task automatic chips(input logic b, output logic [10:0] c);
        logic [31:0] r;
        logic        e;
        apb(1'h1, rbs_pkg::HA_CTRL, {30'h0, b, 1'h1}, r, e);
        lw(200);
        for (int i = 0; i < 11; i++)
        begin
            lw(4);
            c = {c[9:0], mod_out};
        end
    endtask
    // ----------------------------
    // scenarios
    // ----------------------------
    initial
    begin
        #300000;
        errors++;
        complete_run;
    end
    initial
    begin
        logic [7:0]  q;
        logic [31:0] r;
        logic        e;
        logic [10:0] c;
        lw(2);
        rstn <= 1'h1;
        dev(rbs_pkg::RA_RXTX, 8'h0, 1'h1, q);
        check(32'(q), 32'(rbs_pkg::RXTX_RST));
        dev(rbs_pkg::RA_DIV, 8'h0, 1'h1, q);
        check(32'(q), 32'(rbs_pkg::DIV_RST));
        apb(1'h0, 8'h10, 32'h0, r, e);
        check({e, r[30:0]}, 32'h80000000);
        for (int s = 0; s < 4; s++)
        begin
            wr(rbs_pkg::RA_SW0, 8'(s));
            wr(rbs_pkg::RA_SW1, 8'(3 - s));
            for (int t = 0; t < 2; t++)
            begin
                wr(rbs_pkg::RA_SEL, 8'(t));
                lw(4);
                check(32'(fe_mode), 32'(t == 1 ? 3 - s : s));
            end
        end
        wr(rbs_pkg::RA_RXTX, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge lclk);
            demod <= i[0] ^ i[2];
            lw(3);
            check({lnk.recovered_bit_clock, lnk.data_line}, {1'h0, i[0] ^ i[2]});
        end
        wr(rbs_pkg::RA_RXTX, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            wr(rbs_pkg::RA_DIV, 8'(dv[i]));
            lw((dv[i] + 1) * PRE * 3);
            check(32'(per), 32'((dv[i] + 1) * PRE * 12));
        end
        wr(rbs_pkg::RA_EXTRA, 8'h01);
        lw(FIXP * 3);
        check(32'(per), 32'(FIXP * 12));
        wr(rbs_pkg::RA_EXTRA, 8'h00);
        wr(rbs_pkg::RA_DIV, 8'h01);
        rx_run(16'hc3b4, 32, 40, 1'h0, 2 * PRE);
        check(32'(locked), 32'h1);
        apb(1'h0, rbs_pkg::HA_RXD, 32'h0, r, e);
        check(32'(r[9:8]), 32'h3);
        apb(1'h1, rbs_pkg::HA_CTRL, 32'h3, r, e);
        lw(40);
        check(32'(mod_out), 32'h1);
        dev(rbs_pkg::RA_STAT, 8'h0, 1'h1, q);
        check(32'(q[1]), 32'h1);
        apb(1'h1, rbs_pkg::HA_CTRL, 32'h1, r, e);
        lw(40);
        check(32'(mod_out), 32'h0);
        wr(rbs_pkg::RA_DIV, 8'h0a);
        wr(rbs_pkg::RA_RXTX, 8'h02);
        chips(1'h1, c);
        bk = {<<{rbs_pkg::BARKER}};
        if (rot(c, rbs_pkg::BARKER))
            bk = rbs_pkg::BARKER;
        check(32'(rot(c, bk)), 32'h1);
        chips(1'h0, c);
        check(32'(rot(~c, bk)), 32'h1);
        apb(1'h1, rbs_pkg::HA_CTRL, 32'h0, r, e);
        rx_run(16'hc3b4, 8, 6, 1'h1, 44);
        wr(rbs_pkg::RA_RXTX, 8'h01);
        wr(rbs_pkg::RA_DIV, 8'h04);
        rx_run(16'hc3b4, 32, 4, 1'h0, 21);
        complete_run;
    end
endmodule // rx_bit_synchronizer_tb
